/* File: tb_top.sv */
// testbench: registers, compare actions, capture edges, buffer modes
// assumes: pin model and checker compiled first
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic rdPend = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata, rdExp, rdHold;
  logic [15:0] counterValue = 16'h1234;
  logic [3:0] compareMatch = 4'h0;
  logic [3:0] extLevel = 4'h0;
  logic [3:0] pinLevel, timerPinOut, timerPinOe, captureStrobe;
  logic [3:0][15:0] captureValue;
  logic en, lvl;
  int badCount = 0;
  int numChecks = 0;
  int capCnt[4] = '{0, 0, 0, 0};
  int expCnt[4] = '{0, 0, 0, 0};
  initial forever #5 clk = ~clk;
  tioc_channel_io u_dut (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .counterValue(counterValue),
    .compareMatch(compareMatch), .timerPinIn(pinLevel),
    .timerPinOut(timerPinOut), .timerPinOe(timerPinOe),
    .captureStrobe(captureStrobe), .captureValue(captureValue));
  tioc_pin_model u_pins (.extLevel(extLevel), .timerPinOut(timerPinOut),
    .timerPinOe(timerPinOe), .pinLevel(pinLevel));
  task automatic chk(input logic [15:0] g, e);
    numChecks++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // read data only stand one cycle, so they are checked here
  always @(posedge clk) begin
    if (rdPend) chk(regRdata, rdHold);
    rdPend <= regRead;
    rdHold <= rdExp;
    for (int i = 0; i < 4; i++) capCnt[i] += captureStrobe[i];
  end
  task automatic bus(input logic w, r, input logic [1:0] a,
    input logic [7:0] d, input logic [3:0] m);
    @(posedge clk);
    regWrite <= w;
    regRead <= r;
    regAddr <= a;
    regWdata <= d;
    rdExp <= d;
    compareMatch <= m;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d, 4'h0);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, e, 4'h0);
  endtask
  task automatic cyc(input logic [3:0] m);
    bus(1'b0, 1'b0, 2'h0, 8'h00, m);
  endtask
  task automatic look(input logic [3:0] e);
    cyc(4'h0);
    @(negedge clk);
    chk(timerPinOe, e);
  endtask
  task automatic pin(input int i, input logic v);
    cyc(4'h0);
    extLevel[i] <= v;
    repeat (7) cyc(4'h0);
  endtask
  task automatic cmpCnt();
    for (int i = 0; i < 4; i++) chk(capCnt[i], expCnt[i]);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    badCount++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    look(4'h0);
    chk(timerPinOut, 4'h0);
    $display("reset test done");
    wr(2'h0, 8'h21);
    rd(2'h0, 8'h21);
    wr(2'h1, 8'h5A);
    rd(2'h1, 8'h5A);
    look(4'hB);
    chk(timerPinOut, 4'h8);
    wr(2'h3, 8'hFF);
    rd(2'h1, 8'h5A);
    rd(2'h3, 8'h48);
    $display("map test done");
    wr(2'h1, 8'h55);
    wr(2'h2, 8'h01);
    rd(2'h2, 8'h01);
    look(4'hB);
    wr(2'h2, 8'h02);
    look(4'h7);
    wr(2'h2, 8'h00);
    wr(2'h1, 8'h00);
    $display("buffer test done");
    for (int c = 0; c < 8; c++) begin
      en = c[1:0] != 2'h0;
      lvl = c[1:0] == 2'h3 ? ~c[2] : c[1];
      wr(2'h0, 8'(c));
      cyc(4'h1);
      @(negedge clk);
      chk({timerPinOe[0], en & timerPinOut[0]}, {en, en & c[2]});
      repeat (2) cyc(4'h0);
      @(negedge clk);
      chk(en & timerPinOut[0], en & lvl);
    end
    $display("compare test done");
    wr(2'h0, 8'h00);
    pin(0, 1'b0);
    for (int c = 8; c < 16; c++) begin
      wr(2'h0, 8'(c));
      pin(0, 1'b1);
      expCnt[0] += (c[1:0] != 2'h1 && c != 15);
      pin(0, 1'b0);
      expCnt[0] += (c[1:0] != 2'h0 && c != 15);
      cmpCnt();
    end
    chk(captureValue[0], 16'h1234);
    wr(2'h0, 8'h88);
    wr(2'h1, 8'h88);
    for (int i = 0; i < 4; i++) begin
      counterValue <= 16'h1000 + 16'(i);
      pin(i, 1'b1);
      pin(i, 1'b0);
      expCnt[i]++;
      cmpCnt();
      chk(captureValue[i], 16'h1000 + 16'(i));
    end
    wr(2'h2, 8'h03);
    pin(2, 1'b1);
    pin(2, 1'b0);
    pin(3, 1'b1);
    pin(3, 1'b0);
    cmpCnt();
    $display("capture test done");
    end_of_test();
  end
endmodule // tb_top
bind tioc_channel_io tioc_channel_io_asserts u_chk (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .timerPinIn(timerPinIn),
  .timerPinOut(timerPinOut), .timerPinOe(timerPinOe),
  .captureStrobe(captureStrobe));

/* File: tioc_cfg.svh */
// tioc_cfg.svh: constants for the timer channel I/O control block
// assumes: included by its bare name from package and modules
`ifndef TIOC_CFG_SVH
`define TIOC_CFG_SVH
`define TIOC_ADDR_W 2
`define TIOC_OFS_CTRL_HIGH 2'h0
`define TIOC_OFS_CTRL_LOW 2'h1
`define TIOC_OFS_MODE 2'h2
`define TIOC_OFS_STATUS 2'h3
`define TIOC_FIELD_RESET 4'h0
`define TIOC_BIT_BUF_A 0
`define TIOC_BIT_BUF_B 1
`define TIOC_HI_LSB 4
`define TIOC_LO_LSB 0
`endif

/* File: tioc_channel_io.sv */
// tioc_channel_io.sv: I/O control of one timer channel, four pins A..D
// assumes: counter and compare logic outside supply match pulses and
// count; a host on clk reaches the registers over a plain strobe port
`timescale 1ns/1ps
`include "tioc_cfg.svh"
module tioc_channel_io
  import tioc_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [`TIOC_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // counter and compare events, index 0..3 = A..D
  input wire logic [COUNT_W-1:0] counterValue,
  input wire logic [3:0] compareMatch,
  // timer pins A..D
  input wire logic [3:0] timerPinIn,
  output logic [3:0] timerPinOut,
  output logic [3:0] timerPinOe,
  // capture results
  output logic [3:0] captureStrobe,
  output logic [3:0][COUNT_W-1:0] captureValue
);
  // elaboration check: a captured value is at most one 32-bit word
  if (COUNT_W < 1 || COUNT_W > 32) begin : gBadWidth
    $error("COUNT_W out of range");
  end

  logic [7:0] ctrlHigh;
  logic [7:0] ctrlLow;
  logic [1:0] bufMode;
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic [3:0] capPulse;
  logic [3:0] capMode;
  logic [3:0] unitOe;

  wire wrHigh = regWrite && (regAddr == `TIOC_OFS_CTRL_HIGH);
  wire wrLow = regWrite && (regAddr == `TIOC_OFS_CTRL_LOW);
  wire wrMode = regWrite && (regAddr == `TIOC_OFS_MODE);
  wire bufA = bufMode[`TIOC_BIT_BUF_A];
  wire bufB = bufMode[`TIOC_BIT_BUF_B];
  // units see the code being written, so the write edge loads the new
  // code's initial level rather than the old one
  wire [7:0] nextHigh = wrHigh ? regWdata : ctrlHigh;
  wire [7:0] nextLow = wrLow ? regWdata : ctrlLow;
  wire [3:0] fieldA = nextHigh[`TIOC_LO_LSB +: 4];
  wire [3:0] fieldB = nextHigh[`TIOC_HI_LSB +: 4];
  wire [3:0] fieldC = nextLow[`TIOC_LO_LSB +: 4];
  wire [3:0] fieldD = nextLow[`TIOC_HI_LSB +: 4];
  wire [3:0][3:0] fields = {fieldD, fieldC, fieldB, fieldA};
  wire [3:0] ignore = {bufB, bufA, 2'b00};
  wire [3:0] cfgWr = {wrLow, wrLow, wrHigh, wrHigh};
  // enable held off in the write cycle: the old level never drives
  assign timerPinOe = unitOe & ~cfgWr;
  wire [7:0] statusWord = {capMode, timerPinOut};
  logic [7:0] next_regRdata;

  always_comb begin
    case (regAddr)
      `TIOC_OFS_CTRL_HIGH: next_regRdata = ctrlHigh;
      `TIOC_OFS_CTRL_LOW: next_regRdata = ctrlLow;
      `TIOC_OFS_MODE: next_regRdata = {6'h00, bufMode};
      `TIOC_OFS_STATUS: next_regRdata = statusWord;
      default: next_regRdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlHigh <= {`TIOC_FIELD_RESET, `TIOC_FIELD_RESET};
      ctrlLow <= {`TIOC_FIELD_RESET, `TIOC_FIELD_RESET};
      bufMode <= 2'h0;
      regRdata <= 8'h00;
    end else begin
      ctrlHigh <= nextHigh;
      ctrlLow <= nextLow;
      if (wrMode) bufMode <= regWdata[1:0];
      regRdata <= regRead ? next_regRdata : 8'h00;
    end
  end

  // pins are asynchronous: two flops before any edge logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
    end else begin
      pinMeta <= timerPinIn;
      pinSync <= pinMeta;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gUnit
      tioc_unit uUnit (
        .clk(clk),
        .rst(rst),
        .funcField(fields[gi]),
        .ignore(ignore[gi]),
        .cfgWrite(cfgWr[gi]),
        .compareMatch(compareMatch[gi]),
        .pinSync(pinSync[gi]),
        .pinOut(timerPinOut[gi]),
        .pinOe(unitOe[gi]),
        .captureStrobe(capPulse[gi]),
        .isCapture(capMode[gi])
      );

      // counter latched in the same cycle as the strobe
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          captureValue[gi] <= '0;
        end else if (capPulse[gi]) begin
          captureValue[gi] <= counterValue;
        end
      end
    end
  endgenerate

  // strobe and latched value appear at the same edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      captureStrobe <= 4'h0;
    end else begin
      captureStrobe <= capPulse;
    end
  end
endmodule // tioc_channel_io

/* File: tioc_channel_io_asserts.sv */
// port checks for the channel I/O control block
// assumes: bound into tioc_channel_io, one clock domain
`timescale 1ns/1ps
module tioc_channel_io_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  // pins and capture
  input wire logic [3:0] timerPinIn,
  input wire logic [3:0] timerPinOut,
  input wire logic [3:0] timerPinOe,
  input wire logic [3:0] captureStrobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wrA = regWrite && regAddr == 2'h0;
  wire wrM = regWrite && regAddr == 2'h2;
  sequence s_wrRd(a);
    regWrite && regAddr == a ##1 regRead && regAddr == a;
  endsequence
  property p_hi; s_wrRd(2'h0) |=> regRdata == $past(regWdata, 2); endproperty
  a_hi: assert property (p_hi) else $error("high rdata");
  property p_lo; s_wrRd(2'h1) |=> regRdata == $past(regWdata, 2); endproperty
  a_lo: assert property (p_lo) else $error("low rdata");
  // a second write right behind would override the first code
  sequence s_initWr;
    wrA && !regWdata[3] && regWdata[1:0] != 2'h0 ##1 !wrA;
  endsequence
  property p_init; s_initWr |->
    timerPinOe[0] && timerPinOut[0] == $past(regWdata[2]); endproperty
  a_init: assert property (p_init) else $error("init level");
  property p_off; wrA && regWdata[3:0] inside {4'h0, 4'h4} |=>
    !timerPinOe[0]; endproperty
  a_off: assert property (p_off) else $error("pin on");
  property p_cap; wrA && regWdata[3] |=> !timerPinOe[0]; endproperty
  a_cap: assert property (p_cap) else $error("capture drives");
  property p_nul; wrA && regWdata[3:0] == 4'hF |=> !captureStrobe[0] [*8];
  endproperty
  a_nul: assert property (p_nul) else $error("null capture");
  property p_bufC; wrM && regWdata[0] |=> !timerPinOe[2]; endproperty
  a_bufC: assert property (p_bufC) else $error("C not off");
  property p_bufD; wrM && regWdata[1] |=> !timerPinOe[3]; endproperty
  a_bufD: assert property (p_bufD) else $error("D not off");
  // a strobe only where its own pin moved, fixed sync latency
  property p_src; |captureStrobe |-> (captureStrobe &
    ~($past(timerPinIn, 4) ^ $past(timerPinIn, 5))) == 4'h0; endproperty
  a_src: assert property (p_src) else $error("capture source");
endmodule // tioc_channel_io_asserts

/* File: tioc_pin_model.sv */
// far-side drivers on the four timer pins
// assumes: design drives a pin only while its enable is high
`timescale 1ns/1ps
module tioc_pin_model (
  // far side
  input wire logic [3:0] extLevel,
  // design side
  input wire logic [3:0] timerPinOut,
  input wire logic [3:0] timerPinOe,
  output logic [3:0] pinLevel
);
  assign pinLevel = (timerPinOe & timerPinOut) | (~timerPinOe & extLevel);
endmodule // tioc_pin_model

/* File: tioc_pkg.sv */
// tioc_pkg.sv: types shared by the channel I/O control block
// assumes: tioc_cfg.svh on the include path
`include "tioc_cfg.svh"
package tioc_pkg;
  typedef enum logic [1:0] {
    TIOC_ACT_LOW = 2'h0,
    TIOC_ACT_HIGH = 2'h1,
    TIOC_ACT_TOGGLE = 2'h2,
    TIOC_ACT_NONE = 2'h3
  } tioc_act_e;
  typedef struct packed {
    logic capture;
    logic outEn;
    logic initLevel;
    tioc_act_e act;
    logic capRise;
    logic capFall;
  } tioc_func_s;
endpackage

/* File: tioc_unit.sv */
// tioc_unit.sv: one general register's pin function (compare or capture)
// assumes: pin input already synchronised, match pulse on clk
`timescale 1ns/1ps
`include "tioc_cfg.svh"
module tioc_unit
  import tioc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire logic [3:0] funcField,
  input wire logic ignore,
  input wire logic cfgWrite,
  // events
  input wire logic compareMatch,
  input wire logic pinSync,
  // results
  output logic pinOut,
  output logic pinOe,
  output logic captureStrobe,
  output logic isCapture
);
  tioc_func_s fn;
  logic prevPin;
  logic next_pinOut;
  wire rise = pinSync & ~prevPin;
  wire fall = ~pinSync & prevPin;
  wire [1:0] lowBits = funcField[1:0];
  wire upper = funcField[2];

  always_comb begin
    fn = '0;
    fn.act = TIOC_ACT_NONE;
    fn.capture = funcField[3];
    if (!funcField[3]) begin
      fn.initLevel = upper;
      fn.outEn = (lowBits != 2'h0);
      case (lowBits)
        2'h1: fn.act = TIOC_ACT_LOW;
        2'h2: fn.act = TIOC_ACT_HIGH;
        2'h3: fn.act = TIOC_ACT_TOGGLE;
        default: fn.act = TIOC_ACT_NONE;
      endcase
    end else begin
      // both-edge codes 1010, 1011 and 1110 alike; 1111 captures nothing
      case ({upper, lowBits})
        3'h0, 3'h4: fn.capRise = 1'b1;
        3'h1, 3'h5: fn.capFall = 1'b1;
        3'h2, 3'h3, 3'h6: begin
          fn.capRise = 1'b1;
          fn.capFall = 1'b1;
        end
        default: begin
          fn.capRise = 1'b0;
          fn.capFall = 1'b0;
        end
      endcase
    end
    if (ignore) begin
      fn.outEn = 1'b0;
      fn.capRise = 1'b0;
      fn.capFall = 1'b0;
      fn.act = TIOC_ACT_NONE;
    end
  end

  always_comb begin
    next_pinOut = pinOut;
    if (cfgWrite && fn.outEn) begin
      next_pinOut = fn.initLevel;
    end else if (compareMatch && fn.outEn && !fn.capture) begin
      case (fn.act)
        TIOC_ACT_LOW: next_pinOut = 1'b0;
        TIOC_ACT_HIGH: next_pinOut = 1'b1;
        TIOC_ACT_TOGGLE: next_pinOut = ~pinOut;
        default: next_pinOut = pinOut;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinOut <= 1'b0;
      prevPin <= 1'b0;
      captureStrobe <= 1'b0;
    end else begin
      pinOut <= next_pinOut;
      prevPin <= pinSync;
      captureStrobe <= (rise & fn.capRise) | (fall & fn.capFall);
    end
  end

  assign pinOe = fn.outEn & ~fn.capture;
  assign isCapture = fn.capture & ~ignore;
endmodule // tioc_unit
